// File: common/css_pkg.sv
// Package for the composite sync separator: constants and carrier types.
package css_pkg;

  // ==========================================================
  // Register map of the control values presented on ports
  // ==========================================================
  localparam logic [7:0] CTRL_REG_ADDR    = 8'h12;
  localparam int         HSYNC_SEL_BIT    = 4;
  localparam int         VSYNC_SEL_BIT    = 2;
  localparam logic [7:0] THRESH_REG_ADDR  = 8'h0f;
  localparam logic [7:0] THRESH_RESET     = 8'h20;

  // ==========================================================
  // Counter and timing
  // ==========================================================
  localparam int         CNT_WIDTH        = 8;
  localparam logic [7:0] CNT_MAX          = 8'hff;
  localparam logic [7:0] CNT_ZERO         = 8'h00;
  localparam int         MCLK_HZ          = 25000000;
  localparam int         TICK_HZ          = 5000000;
  localparam int         TICK_DIV         = MCLK_HZ / TICK_HZ;
  localparam logic [2:0] TICK_LAST        = 3'(TICK_DIV - 1);

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [1:0] {
    CSS_SEEK  = 2'b01,
    CSS_INVSY = 2'b10
  } css_phase_e;

  typedef struct packed {
    logic hsync;
    logic green_channel_sync;
    logic vsync;
  } css_sync_in_s;

  typedef struct packed {
    logic hsync;
    logic vsync;
    logic vsync_found;
  } css_sync_out_s;

endpackage : css_pkg

// File: src/css_sync_sep.sv
// Sync multiplexers and composite sync separator.
//
// Behaviour
// R1: Control bit 4 picks hsync or green sync; bit 2 picks vsync or separator.
// R2: Separator is an 8-bit counter advancing on a 5 MHz tick.
// R3: Separator works on sync already normalised to active-high.
// R4: Seeking: count up while sync active, down while inactive, floor zero.
// R5: Vertical sync declared present when count exceeds threshold register.
// R6: On detection clear counter, count while inactive, absent at threshold.
// R7: After absence, clear counter and return to seeking; repeats each frame.
// R8: Software sets threshold between widest hsync and vsync pulse counts.
// R9: Threshold register resets to decimal 32.
// R10: Counter saturates at 255 instead of wrapping.
module css_sync_sep (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  // Control register values
  input  wire logic [7:0]             ctrl_reg,
  input  wire logic                   thresh_we,
  input  wire logic [7:0]             thresh_wdata,
  output      logic [7:0]             thresh_q,
  // Sync pins, composite sync already active-high
  input  wire css_pkg::css_sync_in_s  sync_in,
  input  wire logic                   csync_active,
  // Routed syncs
  output      css_pkg::css_sync_out_s sync_out,
  output      logic [7:0]             sep_count
);

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  logic [2:0] cs_sy_q;
  logic [2:0] hs_sy_q;
  logic [2:0] gs_sy_q;
  logic [2:0] vs_sy_q;
  logic       cs_lvl_q;
  logic       hs_lvl_q;
  logic       gs_lvl_q;
  logic       vs_lvl_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cs_sy_q <= 3'h0;
      hs_sy_q <= 3'h0;
      gs_sy_q <= 3'h0;
      vs_sy_q <= 3'h0;
    end else begin
      cs_sy_q <= {cs_sy_q[1:0], csync_active};
      hs_sy_q <= {hs_sy_q[1:0], sync_in.hsync};
      gs_sy_q <= {gs_sy_q[1:0], sync_in.green_channel_sync};
      vs_sy_q <= {vs_sy_q[1:0], sync_in.vsync};
    end
  end

  // A level changes only once stages two and three agree.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cs_lvl_q <= 1'b0;
      hs_lvl_q <= 1'b0;
      gs_lvl_q <= 1'b0;
      vs_lvl_q <= 1'b0;
    end else begin
      if (cs_sy_q[1] == cs_sy_q[2]) cs_lvl_q <= cs_sy_q[2];
      if (hs_sy_q[1] == hs_sy_q[2]) hs_lvl_q <= hs_sy_q[2];
      if (gs_sy_q[1] == gs_sy_q[2]) gs_lvl_q <= gs_sy_q[2];
      if (vs_sy_q[1] == vs_sy_q[2]) vs_lvl_q <= vs_sy_q[2];
    end
  end

  // ==========================================================
  // Threshold register
  // ==========================================================
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      // R9: threshold reset value
      thresh_q <= css_pkg::THRESH_RESET;
    end else if (thresh_we) begin
      thresh_q <= thresh_wdata;
    end
  end

  // ==========================================================
  // 5 MHz tick divider
  // ==========================================================
  logic [2:0] div_q;
  wire        tick = (div_q == css_pkg::TICK_LAST);

  // R2: tick from divider
  always_ff @(posedge mclk) begin
    if (sys_rst) div_q <= 3'h0;
    else         div_q <= tick ? 3'h0 : div_q + 3'h1;
  end

  // ==========================================================
  // Separator
  // ==========================================================
  css_pkg::css_phase_e phase_q;
  css_pkg::css_phase_e phase_d;
  logic [7:0]          cnt_q;
  logic [7:0]          cnt_d;

  wire at_max   = (cnt_q == css_pkg::CNT_MAX);
  wire at_zero  = (cnt_q == css_pkg::CNT_ZERO);
  wire over_thr = (cnt_q > thresh_q);
  wire at_thr   = (cnt_q >= thresh_q);

  always_comb begin
    phase_d = phase_q;
    cnt_d   = cnt_q;
    if (tick) begin
      unique case (phase_q)
        css_pkg::CSS_SEEK: begin
          if (over_thr) begin
            // R5: presence declared; R6: clear on detection
            phase_d = css_pkg::CSS_INVSY;
            cnt_d   = css_pkg::CNT_ZERO;
          end else if (cs_lvl_q) begin
            // R4 R10: count up, saturating; R3: active-high sync
            cnt_d = at_max ? cnt_q : cnt_q + 8'h01;
          end else begin
            // R4: count down to zero
            cnt_d = at_zero ? cnt_q : cnt_q - 8'h01;
          end
        end
        css_pkg::CSS_INVSY: begin
          if (at_thr) begin
            // R7: absence declared, clear and reseek
            phase_d = css_pkg::CSS_SEEK;
            cnt_d   = css_pkg::CNT_ZERO;
          end else if (!cs_lvl_q) begin
            // R6 R10: count inactive time, saturating
            cnt_d = at_max ? cnt_q : cnt_q + 8'h01;
          end
        end
        default: begin
          phase_d = css_pkg::CSS_SEEK;
          cnt_d   = css_pkg::CNT_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      phase_q <= css_pkg::CSS_SEEK;
      cnt_q   <= css_pkg::CNT_ZERO;
    end else begin
      phase_q <= phase_d;
      cnt_q   <= cnt_d;
    end
  end

  // ==========================================================
  // Output multiplexers
  // ==========================================================
  wire sep_vs = (phase_q == css_pkg::CSS_INVSY);
  wire hs_sel = ctrl_reg[css_pkg::HSYNC_SEL_BIT];
  wire vs_sel = ctrl_reg[css_pkg::VSYNC_SEL_BIT];

  // Registered so the muxed syncs are glitch free at the pins.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sync_out <= '0;
    end else begin
      // R1: sync source selection
      sync_out.hsync       <= hs_sel ? gs_lvl_q : hs_lvl_q;
      sync_out.vsync       <= vs_sel ? sep_vs : vs_lvl_q;
      sync_out.vsync_found <= sep_vs;
    end
  end

  assign sep_count = cnt_q;

  // ==========================================================
  // Checks
  // ==========================================================
  AST_UP_SAT: assert property (@(posedge mclk) disable iff (sys_rst) // R10
    tick && phase_q == css_pkg::CSS_SEEK && !over_thr && cs_lvl_q
    |=> cnt_q == ($past(at_max) ? $past(cnt_q) : $past(cnt_q) + 8'h01))
    else $error("Seek count up wrong.");
  AST_DOWN: assert property (@(posedge mclk) disable iff (sys_rst) // R4
    tick && phase_q == css_pkg::CSS_SEEK && !over_thr && !cs_lvl_q
    |=> cnt_q == ($past(at_zero) ? 8'h00 : $past(cnt_q) - 8'h01))
    else $error("Seek count down wrong.");
  AST_DETECT: assert property (@(posedge mclk) disable iff (sys_rst) // R5
    tick && phase_q == css_pkg::CSS_SEEK && over_thr
    |=> phase_q == css_pkg::CSS_INVSY && cnt_q == 8'h00)
    else $error("Vsync presence missed.");
  AST_ABSENT: assert property (@(posedge mclk) disable iff (sys_rst) // R7
    tick && phase_q == css_pkg::CSS_INVSY && at_thr
    |=> phase_q == css_pkg::CSS_SEEK && cnt_q == 8'h00)
    else $error("Vsync absence missed.");
  AST_HOLD: assert property (@(posedge mclk) disable iff (sys_rst) // R6
    tick && phase_q == css_pkg::CSS_INVSY && !at_thr && cs_lvl_q
    |=> $stable(cnt_q))
    else $error("Count moved during active vsync.");
  AST_TICK: assert property (@(posedge mclk) disable iff (sys_rst) // R2
    !tick |=> $stable(cnt_q))
    else $error("Counter moved without tick.");
  AST_TICK_GAP: assert property (@(posedge mclk) disable iff (sys_rst) // R2
    tick |=> !tick ##1 !tick ##1 !tick ##1 !tick ##1 tick)
    else $error("Tick spacing wrong.");
  AST_HMUX: assert property (@(posedge mclk) disable iff (sys_rst) // R1
    1'b1 |=> sync_out.hsync == ($past(hs_sel) ? $past(gs_lvl_q)
                                               : $past(hs_lvl_q)))
    else $error("Hsync mux wrong.");
  AST_VMUX: assert property (@(posedge mclk) disable iff (sys_rst) // R1
    1'b1 |=> sync_out.vsync == ($past(vs_sel) ? $past(sep_vs)
                                               : $past(vs_lvl_q)))
    else $error("Vsync mux wrong.");
  AST_THR_RST: assert property (@(posedge mclk) // R9
    sys_rst |=> thresh_q == css_pkg::THRESH_RESET)
    else $error("Threshold reset value wrong.");

endmodule : css_sync_sep

// File: bench/css_src.sv
// Behavioural graphics source that drives the separate and composite syncs.
module css_src (
  // Clock
  input  wire logic            mclk,
  // Sync pins
  output css_pkg::css_sync_in_s sync_in,
  output logic                  csync_active
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Pin driver
  // ==========================================================
  // Called at a falling edge; levels are {hsync, green, vsync, csync}.
  // sync is already active-high
  task automatic drive(input logic [3:0] lv, input int n);
    {sync_in, csync_active} = lv;
    repeat (n) @(negedge mclk);
  endtask : drive
endmodule : css_src

// File: bench/testbench.sv
// Self-checking testbench for the sync multiplexers and separator.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                   mclk, sys_rst, thresh_we;
  logic [7:0]             ctrl_reg, thresh_wdata, thresh_q, sep_count;
  logic [7:0]             peak;
  css_pkg::css_sync_in_s  sync_in;
  css_pkg::css_sync_out_s sync_out;
  logic                   csync_active;
  int                     err_count, total_checks, cyc;

  css_sync_sep css_sync_sep_inst (.mclk(mclk), .sys_rst(sys_rst),
    .ctrl_reg(ctrl_reg), .thresh_we(thresh_we),
    .thresh_wdata(thresh_wdata), .thresh_q(thresh_q), .sync_in(sync_in),
    .csync_active(csync_active), .sync_out(sync_out),
    .sep_count(sep_count));
  css_src css_src_inst (.mclk(mclk), .sync_in(sync_in),
    .csync_active(csync_active));

  // ==========================================================
  // Clock, peak tracking and hang guard
  // ==========================================================
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (sep_count > peak) peak <= sep_count;
    if (cyc == 10000) begin
      err_count++;
      summarize();
    end
  end

  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_thr(input logic [7:0] v);
    thresh_wdata = v;
    thresh_we    = 1'b1;
    @(negedge mclk);
    thresh_we    = 1'b0;
    chk(thresh_q, v);
  endtask : wr_thr

  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_mux;
    for (int i = 0; i < 4; i++) begin
      ctrl_reg = {3'h0, i[1], 1'b0, i[0], 2'h0};
      css_src_inst.drive(4'b1010, 8);
      chk(8'(sync_out.hsync), 8'(!i[1]));
      chk(8'(sync_out.vsync), 8'(!i[0]));
    end
  endtask : t_mux

  task automatic t_hpulse;
    // Short pulse of five ticks must never reach the threshold.
    peak = 8'h00;
    css_src_inst.drive(4'b0001, 25);
    css_src_inst.drive(4'b0000, 60);
    chk(peak, 8'h05);
    chk(sep_count, 8'h00);
    chk(8'(sync_out.vsync_found), 8'h00);
  endtask : t_hpulse

  task automatic t_frames;
    ctrl_reg = 8'h04;
    for (int f = 0; f < 2; f++) begin
      css_src_inst.drive(4'b0011, 100);
      chk(8'(sync_out.vsync_found), 8'h01);
      chk(sep_count, 8'h00);
      chk(8'(sync_out.vsync), 8'h01);
      css_src_inst.drive(4'b0000, 30);
      chk(8'(sync_out.vsync_found), 8'h01);
      css_src_inst.drive(4'b0000, 60);
      chk(8'(sync_out.vsync_found), 8'h00);
      chk(sep_count, 8'h00);
    end
  endtask : t_frames

  task automatic t_sat;
    wr_thr(8'hff);
    css_src_inst.drive(4'b0001, 1400);
    chk(sep_count, 8'hff);
    chk(8'(sync_out.vsync_found), 8'h00);
    css_src_inst.drive(4'b0000, 1400);
    chk(sep_count, 8'h00);
  endtask : t_sat

  task automatic t_rst;
    // A write during a mid-run reset must lose to the reset value.
    css_src_inst.drive(4'b0001, 40);
    {sys_rst, thresh_we, thresh_wdata} = {1'b1, 1'b1, 8'h30};
    css_src_inst.drive(4'b0000, 2);
    {sys_rst, thresh_we} = 2'b00;
    chk(thresh_q, 8'h20);
    chk(sep_count, 8'h00);
    chk(8'(sync_out.vsync_found), 8'h00);
  endtask : t_rst

  initial begin
    {sys_rst, thresh_we, thresh_wdata, ctrl_reg} = {1'b1, 1'b0, 16'h0};
    {err_count, total_checks, cyc, peak} = '0;
    css_src_inst.drive(4'h0, 2);
    sys_rst = 1'b0;
    chk(thresh_q, 8'h20);
    chk(sep_count, 8'h00);
    t_mux();
    // Threshold sits between the hsync and vsync pulse counts.
    wr_thr(8'h0a);
    t_hpulse();
    t_frames();
    t_sat();
    t_rst();
    summarize();
  end
endmodule : testbench
